// ### logic/ahic_core.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] Narrow mode drives low eight pins only
// [RULE2] Narrow width after power-up
// [RULE3] Narrow reads give low then high byte
// [RULE4] Wide mode moves whole word per access
// [RULE5] Write edge chosen by write edge select
// [RULE6] Standby command holds busy high
// [RULE7] Other command leaves standby, busy low; code holds busy high after cal and auto-zero commands until they finish
// [RULE8] Power-up lands in standby, busy high
// [RULE9] Trigger bit set: strobe pin input edges
// [RULE10] Power-up in external trigger mode
// [RULE11] Internal mode drives strobe high converting
// [RULE12] Internal acquisition counts 9/15/47/79 clocks
// [RULE13] Completed read raises busy, starts count
// [RULE14] External mode ignores length; strobe ends it
// [RULE15] Calibration averages eight offset measurements
// [RULE16] Calibration averages eight per-capacitor errors
// [RULE17] Coefficients correct every conversion result
// [RULE18] Auto-zero measures offset exactly once
// [RULE19] Host accesses only while busy low
// [RULE20] Host sets wide width first if wanted
// [RULE21] Command codes standby,cal,zero,idle,start
// [RULE22] Length codes map to 9,15,47,79
// [RULE23] Writes hit control, reads give result
// [RULE24] Two's complement result, sign-extended byte
// [RULE25] Strobes act only with chip select low
module ahic_core (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Host bus
  input  wire logic        chip_select_n,
  input  wire logic        read_strobe_n,
  input  wire logic        store_strobe_n,
  input  wire logic        write_edge_select,
  input  wire logic [12:0] data_in,
  output logic      [12:0] data_out,
  output logic      [12:0] data_oe_n,
  output logic             busy_indicator_n,
  // Sample strobe pin
  input  wire logic        sample_strobe_in,
  output logic             sample_strobe_out,
  output logic             sample_strobe_oe_n,
  // Measurement engine
  output logic             meas_req,
  output logic      [1:0]  meas_kind,
  output logic      [3:0]  meas_cap,
  input  wire logic        meas_ack,
  input  wire logic [12:0] meas_value
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ahic_pkg::ahic_state_e state_ff, nxt_state;
  logic [7:0]  ctrl_ff, nxt_ctrl;
  logic [12:0] result_ff;
  logic        byte_sel_ff, nxt_byte_sel;
  logic [6:0]  cnt_ff, nxt_cnt;
  logic [2:0]  rep_ff, nxt_rep;
  logic [3:0]  cap_ff, nxt_cap;
  logic [15:0] acc_ff, nxt_acc;
  logic [12:0] data_out_ff, nxt_data_out;
  logic [12:0] data_oe_n_ff, nxt_data_oe_n;
  logic        busy_n_ff, strobe_out_ff, strobe_oe_n_ff;
  logic        meas_req_ff;
  logic [1:0]  meas_kind_ff, nxt_meas_kind;
  logic [3:0]  meas_cap_ff;
  logic        ofs_we, lin_we;

  // ----------------------------------------
  // Strobe decoding
  // ----------------------------------------
  logic [2:0]  rise, fall;
  logic        rd_act, rd_done, read_complete, wr_take, sync_rise;
  logic        wide, trig_ext, ack_ok, measuring;
  logic [2:0]  wr_cmd, cur_cmd;
  logic [6:0]  acq_len;
  logic [15:0] acc_sum;
  logic [12:0] avg, corrected;
  logic [7:0]  hi_byte;

  ahic_edge #(.W(3), .IDLE(ahic_pkg::EDGE_IDLE)) u_edge (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sig     ({sample_strobe_in, store_strobe_n, read_strobe_n}),
    .rise    (rise),
    .fall    (fall)
  );

  assign wide     = ctrl_ff[ahic_pkg::WIDTH_BIT];
  assign trig_ext = ctrl_ff[ahic_pkg::TRIG_BIT];
  assign cur_cmd  = ctrl_ff[ahic_pkg::CMD_LSB +: 3];
  assign wr_cmd   = data_in[ahic_pkg::CMD_LSB +: 3];
  assign rd_act   = ~chip_select_n & ~read_strobe_n; // [RULE25]
  assign rd_done  = ~chip_select_n & rise[0]; // [RULE25]
  // Narrow reads pair up; only the high byte finishes the read
  assign read_complete = rd_done & (wide | byte_sel_ff); // [RULE3]
  assign wr_take = ~chip_select_n &
                   (write_edge_select ? fall[1] : rise[1]); // [RULE5]
  // Edge of the pin is seen only while it is an input
  assign sync_rise = trig_ext & rise[2]; // [RULE9]
  assign ack_ok    = meas_ack & meas_req_ff;
  assign acc_sum   = acc_ff + {{3{meas_value[12]}}, meas_value};
  // Sum of eight fits in 16 bits; the shift is the average
  assign avg       = acc_sum[15:3]; // [RULE15] [RULE16]
  assign hi_byte   = {{3{result_ff[12]}}, result_ff[12:8]}; // [RULE24]
  assign nxt_ctrl  = wr_take ? data_in[7:0] : ctrl_ff; // [RULE23]

  // Acquisition length lookup
  assign acq_len =
    (ctrl_ff[ahic_pkg::ACQ_LSB +: 2] == 2'h0) ? ahic_pkg::ACQ_CYC0 :
    (ctrl_ff[ahic_pkg::ACQ_LSB +: 2] == 2'h1) ? ahic_pkg::ACQ_CYC1 :
    (ctrl_ff[ahic_pkg::ACQ_LSB +: 2] == 2'h2) ? ahic_pkg::ACQ_CYC2 :
                                                ahic_pkg::ACQ_CYC3; // [RULE22]

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_rep   = rep_ff;
    nxt_cap   = cap_ff;
    nxt_acc   = acc_ff;
    ofs_we    = 1'b0;
    lin_we    = 1'b0;
    if (wr_take) begin
      nxt_rep = 3'h0;
      nxt_cap = 4'h0;
      nxt_acc = 16'h0000;
      case (wr_cmd) // [RULE21]
        ahic_pkg::CMD_STANDBY: nxt_state = ahic_pkg::ST_STANDBY; // [RULE6]
        ahic_pkg::CMD_FULCAL:  nxt_state = ahic_pkg::ST_CAL_OFS;
        ahic_pkg::CMD_AZERO:   nxt_state = ahic_pkg::ST_AZ;
        ahic_pkg::CMD_START:   nxt_state = ahic_pkg::ST_READY; // [RULE7]
        default:               nxt_state = ahic_pkg::ST_IDLE; // [RULE7]
      endcase
    end else begin
      case (state_ff)
        ahic_pkg::ST_READY: begin
          if (sync_rise) begin
            nxt_state = ahic_pkg::ST_CONV;
          end else if (read_complete && trig_ext) begin
            nxt_state = ahic_pkg::ST_WAIT_SYNC; // [RULE14]
          end else if (read_complete) begin
            nxt_state = ahic_pkg::ST_ACQ; // [RULE13]
            nxt_cnt   = acq_len - 7'h01; // [RULE12]
          end
        end
        ahic_pkg::ST_WAIT_SYNC: begin
          if (sync_rise) nxt_state = ahic_pkg::ST_CONV; // [RULE14]
        end
        ahic_pkg::ST_ACQ: begin
          if (cnt_ff == 7'h00) nxt_state = ahic_pkg::ST_CONV; // [RULE12]
          else                 nxt_cnt   = cnt_ff - 7'h01;
        end
        ahic_pkg::ST_CONV: begin
          if (ack_ok) nxt_state = ahic_pkg::ST_READY;
        end
        ahic_pkg::ST_CAL_OFS: begin
          if (ack_ok) begin
            nxt_acc = acc_sum;
            nxt_rep = rep_ff + 3'h1;
            if (rep_ff == ahic_pkg::REP_LAST) begin
              ofs_we    = 1'b1; // [RULE15]
              nxt_acc   = 16'h0000;
              nxt_state = ahic_pkg::ST_CAL_CAP;
            end
          end
        end
        ahic_pkg::ST_CAL_CAP: begin
          if (ack_ok) begin
            nxt_acc = acc_sum;
            nxt_rep = rep_ff + 3'h1;
            if (rep_ff == ahic_pkg::REP_LAST) begin
              lin_we  = 1'b1; // [RULE16]
              nxt_acc = 16'h0000;
              nxt_cap = cap_ff + 4'h1;
              if (cap_ff == ahic_pkg::CAP_LAST)
                nxt_state = ahic_pkg::ST_IDLE;
            end
          end
        end
        ahic_pkg::ST_AZ: begin
          if (ack_ok) begin
            ofs_we    = 1'b1; // [RULE18]
            nxt_state = ahic_pkg::ST_IDLE;
          end
        end
        default: nxt_state = state_ff;
      endcase
    end
  end

  // One sample rides straight into the offset in auto-zero
  ahic_corrector #(.W(13), .CAPS(ahic_pkg::CAPS)) u_corr (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .ofs_we        (ofs_we),
    .lin_we        (lin_we),
    .lin_idx       (cap_ff),
    .coef_in       (state_ff == ahic_pkg::ST_AZ ? meas_value : avg),
    .positive_only (ctrl_ff[ahic_pkg::POS_BIT]),
    .raw           (meas_value),
    .corrected     (corrected)
  ); // [RULE17]

  // ----------------------------------------
  // Output and bus next values
  // ----------------------------------------
  assign measuring = (nxt_state == ahic_pkg::ST_CONV) ||
                     (nxt_state == ahic_pkg::ST_CAL_OFS) ||
                     (nxt_state == ahic_pkg::ST_CAL_CAP) ||
                     (nxt_state == ahic_pkg::ST_AZ);
  assign nxt_meas_kind =
    (nxt_state == ahic_pkg::ST_CONV)    ? ahic_pkg::MK_SAMPLE :
    (nxt_state == ahic_pkg::ST_CAL_CAP) ? ahic_pkg::MK_CAP :
                                          ahic_pkg::MK_OFFSET;
  // Width bit in force before this cycle's write
  assign nxt_data_out = wide ? result_ff : // [RULE4]
                        {5'h00, byte_sel_ff ? hi_byte
                                            : result_ff[7:0]}; // [RULE3]
  assign nxt_data_oe_n = !rd_act ? 13'h1FFF :
                         wide    ? 13'h0000 : 13'h1F00; // [RULE1]
  assign nxt_byte_sel = wr_take ? 1'b0 :
                        (rd_done && !wide) ? ~byte_sel_ff :
                        (wide ? 1'b0 : byte_sel_ff);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ahic_pkg::ST_STANDBY; // [RULE8]
      ctrl_ff  <= ahic_pkg::CTRL_RESET; // [RULE2] [RULE10]
      cnt_ff   <= 7'h00;
      rep_ff   <= 3'h0;
      cap_ff   <= 4'h0;
      acc_ff   <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff  <= nxt_ctrl;
      cnt_ff   <= nxt_cnt;
      rep_ff   <= nxt_rep;
      cap_ff   <= nxt_cap;
      acc_ff   <= nxt_acc;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_ff   <= ahic_pkg::RES_RESET;
      byte_sel_ff <= 1'b0;
    end else begin
      if (state_ff == ahic_pkg::ST_CONV && ack_ok && !wr_take)
        result_ff <= corrected; // [RULE17]
      byte_sel_ff <= nxt_byte_sel;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_out_ff    <= 13'h0000;
      data_oe_n_ff   <= 13'h1FFF;
      busy_n_ff      <= 1'b1;
      strobe_out_ff  <= 1'b0;
      strobe_oe_n_ff <= 1'b1;
      meas_req_ff    <= 1'b0;
      meas_kind_ff   <= ahic_pkg::MK_OFFSET;
      meas_cap_ff    <= 4'h0;
    end else begin
      data_out_ff    <= nxt_data_out;
      data_oe_n_ff   <= nxt_data_oe_n;
      busy_n_ff      <= !(nxt_state == ahic_pkg::ST_IDLE ||
                          nxt_state == ahic_pkg::ST_READY); // [RULE6] [RULE7]
      strobe_out_ff  <= (nxt_state == ahic_pkg::ST_CONV) &&
                        !nxt_ctrl[ahic_pkg::TRIG_BIT]; // [RULE11]
      strobe_oe_n_ff <= nxt_ctrl[ahic_pkg::TRIG_BIT]; // [RULE9] [RULE11]
      // Request drops for a cycle after each answer
      meas_req_ff    <= measuring && !ack_ok;
      meas_kind_ff   <= nxt_meas_kind;
      meas_cap_ff    <= nxt_cap;
    end
  end

  assign data_out           = data_out_ff;
  assign data_oe_n          = data_oe_n_ff;
  assign busy_indicator_n   = busy_n_ff;
  assign sample_strobe_out  = strobe_out_ff;
  assign sample_strobe_oe_n = strobe_oe_n_ff;
  assign meas_req           = meas_req_ff;
  assign meas_kind          = meas_kind_ff;
  assign meas_cap           = meas_cap_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_narrow_float;
    !wide |=> data_oe_n[12:8] == 5'h1F;
  endproperty
  a_narrow_float: assert property (p_narrow_float) // [RULE1]
    else $error("upper pins driven in narrow mode");

  property p_wide_drive;
    (rd_act && wide && !wr_take) |=> data_oe_n == 13'h0000;
  endproperty
  a_wide_drive: assert property (p_wide_drive) // [RULE4]
    else $error("wide read not driving all pins");

  property p_powerup;
    $fell(rst) |-> busy_indicator_n && sample_strobe_oe_n && !wide;
  endproperty
  a_powerup: assert property (p_powerup) // [RULE8]
    else $error("power-up state wrong");

  property p_byte_toggle;
    (rd_done && !wide && !wr_take) |=> byte_sel_ff != $past(byte_sel_ff);
  endproperty
  a_byte_toggle: assert property (p_byte_toggle) // [RULE3]
    else $error("narrow read pointer did not alternate");

  property p_write_edge;
    (wr_take && write_edge_select) |-> fall[1] ##1
      ctrl_ff == $past(data_in[7:0]);
  endproperty
  a_write_edge: assert property (p_write_edge) // [RULE5]
    else $error("write not latched on chosen edge");

  property p_standby;
    (wr_take && wr_cmd == ahic_pkg::CMD_STANDBY) |=>
      busy_indicator_n[*2];
  endproperty
  a_standby: assert property (p_standby) // [RULE6]
    else $error("busy not high in standby");

  property p_leave_standby;
    (state_ff == ahic_pkg::ST_STANDBY && wr_take &&
     wr_cmd == ahic_pkg::CMD_IDLE) |=> !busy_indicator_n;
  endproperty
  a_leave_standby: assert property (p_leave_standby) // [RULE7]
    else $error("busy not low after leaving standby");

  property p_acq_nine;
    (state_ff == ahic_pkg::ST_READY && read_complete && !trig_ext &&
     ctrl_ff[1:0] == 2'h0 && !wr_take && !sync_rise) |=>
      busy_indicator_n ##8 !sample_strobe_out ##1 sample_strobe_out;
  endproperty
  a_acq_nine: assert property (p_acq_nine) // [RULE12] [RULE13]
    else $error("acquisition length not nine clocks");

  property p_sync_start;
    (sync_rise && !wr_take && (state_ff == ahic_pkg::ST_READY ||
     state_ff == ahic_pkg::ST_WAIT_SYNC)) |=>
      state_ff == ahic_pkg::ST_CONV && !sample_strobe_out;
  endproperty
  a_sync_start: assert property (p_sync_start) // [RULE9] [RULE14]
    else $error("strobe edge did not start conversion");

  property p_cal_eight;
    (state_ff == ahic_pkg::ST_CAL_OFS && ack_ok && !wr_take &&
     rep_ff == ahic_pkg::REP_LAST) |=>
      state_ff == ahic_pkg::ST_CAL_CAP && rep_ff == 3'h0;
  endproperty
  a_cal_eight: assert property (p_cal_eight) // [RULE15]
    else $error("offset calibration count wrong");

  property p_az_once;
    (state_ff == ahic_pkg::ST_AZ && ack_ok && !wr_take) |=>
      state_ff == ahic_pkg::ST_IDLE && !busy_indicator_n;
  endproperty
  a_az_once: assert property (p_az_once) // [RULE18]
    else $error("auto-zero took more than one measurement");

  property p_cs_ignore;
    chip_select_n |=> ctrl_ff == $past(ctrl_ff);
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) // [RULE25]
    else $error("write taken without chip select");

  c_conv:  cover property (state_ff == ahic_pkg::ST_CONV && ack_ok);
  c_cal:   cover property (lin_we && cap_ff == ahic_pkg::CAP_LAST);
  c_az:    cover property (state_ff == ahic_pkg::ST_AZ && ack_ok);
  c_narrw: cover property (read_complete && !wide);
endmodule

// ### logic/ahic_pkg.sv
package ahic_pkg;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int          DW          = 13;
  localparam logic [7:0]  CTRL_RESET  = 8'h10;
  localparam logic [12:0] RES_RESET   = 13'h0000;
  localparam logic [2:0]  EDGE_IDLE   = 3'h3;
  // ----------------------------------------
  // Control word fields
  // ----------------------------------------
  localparam int ACQ_LSB   = 0;
  localparam int POS_BIT   = 2;
  localparam int WIDTH_BIT = 3;
  localparam int TRIG_BIT  = 4;
  localparam int CMD_LSB   = 5;
  // ----------------------------------------
  // Commands
  // ----------------------------------------
  localparam logic [2:0] CMD_STANDBY = 3'h0;
  localparam logic [2:0] CMD_FULCAL  = 3'h1;
  localparam logic [2:0] CMD_AZERO   = 3'h2;
  localparam logic [2:0] CMD_IDLE    = 3'h3;
  localparam logic [2:0] CMD_START   = 3'h4;
  // ----------------------------------------
  // Counts
  // ----------------------------------------
  localparam logic [6:0] ACQ_CYC0  = 7'h09;
  localparam logic [6:0] ACQ_CYC1  = 7'h0F;
  localparam logic [6:0] ACQ_CYC2  = 7'h2F;
  localparam logic [6:0] ACQ_CYC3  = 7'h4F;
  localparam logic [2:0] REP_LAST  = 3'h7;
  localparam logic [3:0] CAP_LAST  = 4'hB;
  localparam int         CAPS      = 12;
  // ----------------------------------------
  // Measurement kinds and states
  // ----------------------------------------
  localparam logic [1:0] MK_OFFSET = 2'h0;
  localparam logic [1:0] MK_CAP    = 2'h1;
  localparam logic [1:0] MK_SAMPLE = 2'h2;
  typedef enum logic [3:0] {
    ST_STANDBY, ST_IDLE, ST_READY, ST_ACQ, ST_WAIT_SYNC,
    ST_CONV, ST_CAL_OFS, ST_CAL_CAP, ST_AZ
  } ahic_state_e;
endpackage

// ### logic/ahic_edge.sv
`timescale 1ns/1ps
module ahic_edge #(
  parameter int         W    = 3,
  parameter logic [2:0] IDLE = ahic_pkg::EDGE_IDLE
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Levels and their edges
  input  wire logic [W-1:0] sig,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] prev_ff;

  if (W > 3) begin : g_bad
    $error("ahic_edge: W above 3 not served");
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) prev_ff <= IDLE[W-1:0];
    else     prev_ff <= sig;
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    assign rise[i] = sig[i] & ~prev_ff[i];
    assign fall[i] = ~sig[i] & prev_ff[i];
  end
endmodule

// ### logic/ahic_corrector.sv
`timescale 1ns/1ps
module ahic_corrector #(
  parameter int W    = 13,
  parameter int CAPS = 12
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Coefficient loading
  input  wire logic         ofs_we,
  input  wire logic         lin_we,
  input  wire logic [3:0]   lin_idx,
  input  wire logic [W-1:0] coef_in,
  // Correction path
  input  wire logic         positive_only,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] corrected
);
  logic [W-1:0] ofs_ff;
  logic [W-1:0] lin_ff [CAPS];
  logic [W-1:0] part [CAPS+1];
  logic [W-1:0] diff;

  if (CAPS > W - 1 || CAPS > 16) begin : g_bad
    $error("ahic_corrector: CAPS too large for W");
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ofs_ff <= '0;
      for (int i = 0; i < CAPS; i++) lin_ff[i] <= '0;
    end else begin
      if (ofs_we) ofs_ff <= coef_in;
      for (int i = 0; i < CAPS; i++)
        if (lin_we && lin_idx == 4'(i)) lin_ff[i] <= coef_in;
    end
  end

  // Each set weight bit removes its own capacitor error
  assign part[0] = '0;
  for (genvar i = 0; i < CAPS; i++) begin : g_lin
    assign part[i+1] = part[i] + (raw[i] ? lin_ff[i] : '0);
  end

  assign diff      = raw - ofs_ff - part[CAPS];
  assign corrected = (positive_only && diff[W-1]) ? '0 : diff;
endmodule

// ### bench/ahic_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host bus model
// ----------------------------------------
module ahic_host (
  // Clock
  input  wire logic        clk_sys,
  // Toward the device
  output logic             chip_select_n,
  output logic             read_strobe_n,
  output logic             store_strobe_n,
  output logic             write_edge_select,
  output logic      [12:0] data_in,
  // From the device
  input  wire logic [12:0] data_out,
  input  wire logic [12:0] data_oe_n,
  input  wire logic        busy_indicator_n
);
  initial begin
    chip_select_n     = 1'b1;
    read_strobe_n     = 1'b1;
    store_strobe_n    = 1'b1;
    write_edge_select = 1'b1;
    data_in           = 13'h0000;
  end

  // Only standby accesses may skip the ready wait
  task automatic wait_ready(input logic skip, output logic ok);
    ok = 1'b1;
    if (!skip) begin
      ok = 1'b0;
      for (int i = 0; i < 3000 && !ok; i++) begin
        @(negedge clk_sys);
        ok = (busy_indicator_n === 1'b0);
      end
    end
  endtask

  // Data changes between the strobe edges, so the capture edge shows
  task automatic write_ctrl(input logic wes, input logic [7:0] v1,
                            input logic [7:0] v2, input logic cs_v,
                            input logic skip, output logic ok);
    wait_ready(skip, ok);
    @(negedge clk_sys);
    write_edge_select = wes;
    @(negedge clk_sys);
    chip_select_n  = cs_v;
    data_in        = {5'h00, v1};
    store_strobe_n = 1'b0;
    @(negedge clk_sys);
    data_in = {5'h00, v2};
    @(negedge clk_sys);
    store_strobe_n = 1'b1;
    @(negedge clk_sys);
    chip_select_n = 1'b1;
    // Released bus must not keep showing the last value
    data_in = ~data_in;
    @(negedge clk_sys);
  endtask

  // Narrow mode needs two of these per result
  task automatic read_word(input logic skip, output logic [12:0] d,
                           output logic [12:0] oe, output logic ok);
    wait_ready(skip, ok);
    @(negedge clk_sys);
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    d  = data_out;
    oe = data_oe_n;
    read_strobe_n = 1'b1;
    @(negedge clk_sys);
    chip_select_n = 1'b1;
  endtask
endmodule

// ### bench/adc_host_interface_control_bench.sv
`timescale 1ns/1ps
module adc_host_interface_control_bench;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [12:0] raw;
    logic [12:0] exp;
    logic [6:0]  acq;
  } ahic_row_s;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        chip_select_n, read_strobe_n, store_strobe_n;
  logic        write_edge_select, busy_indicator_n;
  logic [12:0] data_in, data_out, data_oe_n;
  logic        sample_strobe_out, sample_strobe_oe_n, ss_drv = 1'b0;
  logic        meas_req, meas_ack = 1'b0;
  logic [1:0]  meas_kind;
  logic [3:0]  meas_cap;
  logic [12:0] meas_value = 13'h0000;
  logic [12:0] ofs_v = 13'h0000, cap0_v = 13'h0000, samp_v = 13'h0000;
  logic        busy_q, ss_q, ss_at_ack;
  logic [6:0]  acq_cnt = 7'h00, acq_seen = 7'h00;
  int          eng_delay = 0, eng_cnt = 0, n_ofs = 0, n_cap = 0;
  int          mismatches = 0, comparisons = 0;
  wire         ss_pin = sample_strobe_oe_n ? ss_drv : sample_strobe_out;
  ahic_row_s   rows [5] = '{
    '{8'h88, 13'h0123, 13'h0123, ahic_pkg::ACQ_CYC0},
    '{8'h89, 13'h1F00, 13'h1F00, ahic_pkg::ACQ_CYC1},
    '{8'h8E, 13'h1F00, 13'h0000, ahic_pkg::ACQ_CYC2},
    '{8'h8F, 13'h0FFF, 13'h0FFF, ahic_pkg::ACQ_CYC3},
    '{8'h80, 13'h1234, 13'h1234, ahic_pkg::ACQ_CYC0}};

  always #2.5 clk_sys = ~clk_sys;

  ahic_core i_dut (.clk_sys(clk_sys), .rst(rst),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .store_strobe_n(store_strobe_n),
    .write_edge_select(write_edge_select), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n),
    .busy_indicator_n(busy_indicator_n), .sample_strobe_in(ss_pin),
    .sample_strobe_out(sample_strobe_out),
    .sample_strobe_oe_n(sample_strobe_oe_n), .meas_req(meas_req),
    .meas_kind(meas_kind), .meas_cap(meas_cap), .meas_ack(meas_ack),
    .meas_value(meas_value));

  ahic_host i_host (.clk_sys(clk_sys), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .store_strobe_n(store_strobe_n),
    .write_edge_select(write_edge_select), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n),
    .busy_indicator_n(busy_indicator_n));

  // ----------------------------------------
  // Measurement engine and acquisition monitor
  // ----------------------------------------
  always @(negedge clk_sys) begin
    meas_ack   <= 1'b0;
    meas_value <= ~meas_value;
    if (meas_req === 1'b1 && !meas_ack) begin
      if (eng_cnt < eng_delay) begin
        eng_cnt <= eng_cnt + 1;
      end else begin
        eng_cnt  <= 0;
        meas_ack <= 1'b1;
        case (meas_kind)
          ahic_pkg::MK_OFFSET: begin
            meas_value <= ofs_v;
            n_ofs      <= n_ofs + 1;
          end
          ahic_pkg::MK_CAP: begin
            meas_value <= (meas_cap == 4'h0) ? cap0_v : 13'h0000;
            n_cap      <= n_cap + 1;
          end
          default: meas_value <= samp_v;
        endcase
      end
    end
  end

  // Counts from busy rising to the strobe output rising
  always @(posedge clk_sys) begin
    busy_q  <= busy_indicator_n;
    ss_q    <= sample_strobe_out;
    acq_cnt <= (!busy_q && busy_indicator_n) ? 7'h01 : acq_cnt + 7'h01;
    if (!ss_q && sample_strobe_out) acq_seen <= acq_cnt;
    if (meas_ack) ss_at_ack <= sample_strobe_out;
  end

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      mismatches++;
    end
  endtask

  task automatic need(input logic ok);
    check("ready_wait", 16'h0001, {15'h0000, ok});
    if (ok !== 1'b1) finish_test();
  endtask

  task automatic read_result(input logic wide, output logic [15:0] v);
    logic [12:0] d, o;
    logic        ok;
    i_host.read_word(1'b0, d, o, ok);
    need(ok);
    check("data_oe_n", wide ? 16'h0000 : 16'h1F00, {3'h0, o});
    v = {3'h0, d};
    if (!wide) begin
      v[7:0] = d[7:0];
      i_host.read_word(1'b0, d, o, ok);
      need(ok);
      v[15:8] = d[7:0];
    end
  endtask

  task automatic wr(input logic wes, input logic [7:0] v1,
                    input logic [7:0] v2, input logic cs_v,
                    input logic skip);
    logic ok;
    i_host.write_ctrl(wes, v1, v2, cs_v, skip, ok);
    need(ok);
  endtask

  task automatic busy_is(input logic exp);
    check("busy_indicator_n", {15'h0000, exp}, {15'h0000, busy_indicator_n});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [12:0] d, o;
    logic [15:0] v;
    logic        ok, w;
    int          ofs_base, cap_base;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    busy_is(1'b1);
    check("sample_strobe_oe_n", 16'h1, 16'(sample_strobe_oe_n));
    check("data_oe_n", 16'h1FFF, {3'h0, data_oe_n});
    i_host.read_word(1'b1, d, o, ok);
    need(ok);
    check("data_oe_n", 16'h1F00, {3'h0, o});
    wr(1'b0, 8'h68, 8'h08, 1'b0, 1'b1);
    busy_is(1'b1);
    wr(1'b1, 8'h68, 8'h08, 1'b0, 1'b1);
    busy_is(1'b0);
    wr(1'b1, 8'h08, 8'h08, 1'b0, 1'b0);
    busy_is(1'b1);
    wr(1'b1, 8'h68, 8'h68, 1'b1, 1'b1);
    busy_is(1'b1);
    wr(1'b1, 8'h68, 8'h68, 1'b0, 1'b1);
    busy_is(1'b0);
    foreach (rows[i]) begin
      w = rows[i].ctrl[3];
      wr(1'b1, rows[i].ctrl, rows[i].ctrl, 1'b0, 1'b0);
      check("sample_strobe_oe_n", 16'h0, 16'(sample_strobe_oe_n));
      samp_v = rows[i].raw;
      read_result(w, v);
      i_host.wait_ready(1'b0, ok);
      need(ok);
      check("acq_cycles", 16'(rows[i].acq), 16'(acq_seen));
      check("strobe_at_ack", 16'h1, {15'h0, ss_at_ack});
      read_result(w, v);
      check("result", w ? {3'h0, rows[i].exp}
            : {{3{rows[i].exp[12]}}, rows[i].exp}, v);
    end
    wr(1'b1, 8'h9B, 8'h9B, 1'b0, 1'b0);
    check("sample_strobe_oe_n", 16'h1, 16'(sample_strobe_oe_n));
    samp_v = 13'h0055;
    i_host.read_word(1'b0, d, o, ok);
    need(ok);
    repeat (100) @(negedge clk_sys);
    check("meas_req", 16'h0, {15'h0, meas_req});
    ss_drv = 1'b1;
    for (int i = 0; i < 4 && meas_req !== 1'b1; i++) @(negedge clk_sys);
    check("meas_req", 16'h1, {15'h0, meas_req});
    ss_drv = 1'b0;
    read_result(1'b1, v);
    check("result", 16'h0055, v);
    ss_drv = 1'b1;
    repeat (3) @(negedge clk_sys);
    ss_drv = 1'b0;
    // Counters belong to the engine model; snapshots avoid a second driver
    ofs_base  = n_ofs;
    cap_base  = n_cap;
    ofs_v     = 13'h0008;
    cap0_v    = 13'h0008;
    eng_delay = 3;
    wr(1'b1, 8'h28, 8'h28, 1'b0, 1'b0);
    busy_is(1'b1);
    i_host.wait_ready(1'b0, ok);
    need(ok);
    check("offset_meas", 16'd8, 16'(n_ofs - ofs_base));
    check("cap_meas", 16'd96, 16'(n_cap - cap_base));
    eng_delay = 0;
    wr(1'b1, 8'h88, 8'h88, 1'b0, 1'b0);
    samp_v = 13'h0101;
    read_result(1'b1, v);
    read_result(1'b1, v);
    check("result", 16'h00F1, v);
    ofs_base = n_ofs;
    cap_base = n_cap;
    wr(1'b1, 8'h48, 8'h48, 1'b0, 1'b0);
    i_host.wait_ready(1'b0, ok);
    need(ok);
    check("offset_meas", 16'd1, 16'(n_ofs - ofs_base));
    check("cap_meas", 16'd0, 16'(n_cap - cap_base));
    finish_test();
  end
endmodule
